// >>> hdl/nvp_pkg.sv
// How it works
// - EPROM latch set, program clear: EPROM writes capture address and eight bytes.
// - EPROM latch clear: EPROM array reads normally, EPROM program bit forced to zero.
// - STOP or any reset clears both latch bits.
// - EPROM program bit sets only after latch and one byte; latch clear clears it.
// - EPROM pair: 00 read, 10 load, 11 programming.
// - EEPROM latch and pump set: erase select picks erase or program.
// - Erase select is frozen once the EEPROM address is captured.
// - EEPROM latch set, pump clear: writes capture; latch clear zeroes select, pump.
// - Pump bit switches the charge pump and high voltage onto the array.
// - Pump sets only after data capture; only latch clear or reset clears it.
// - EEPROM triple decodes read, load, program, erase load, erase.
// - Reset pin held low 16 or 4064 cycles after power-on, per option.
// - Watchdog-after-reset option enables watchdog at reset, not in bootstrap.
// - Watchdog-in-wait option keeps watchdog running in WAIT.
// - Pull-down options act on port B or C pins that are inputs.
// - Upper 224 EEPROM bytes refuse erase and program while protected.
// - Protection state taken at reset persists until next reset.
// - Protect bit changes only through EEPROM capture with latch set.
// - Bootstrap mode ignores upper-region protection.
// - Lock bit zero refuses non-user modes; one allows them.
// - Lock bit changes take effect only at the next reset.
package nvp_pkg;
  localparam logic [15:0] CTRL_ADDR = 16'h0007;
  localparam logic [15:0] OPT_ADDR = 16'h0100;
  localparam logic [15:0] MOR_ADDR = 16'h3dfe;
  localparam logic [15:0] EE_LO = 16'h0100;
  localparam logic [15:0] EE_HI = 16'h01ff;
  localparam logic [15:0] EE_UPPER_LO = 16'h0120;
  localparam logic [15:0] EPROM_LO = 16'h0800;
  localparam logic [15:0] EPROM_HI = 16'h3fff;
  localparam int CTRL_ELAT = 5;
  localparam int CTRL_EPGM = 4;
  localparam int CTRL_ERA = 2;
  localparam int CTRL_ILAT = 1;
  localparam int CTRL_IPGM = 0;
  localparam int OPT_PROT = 1;
  localparam int OPT_LOCK = 0;
  localparam int MOR_HOLD = 4;
  localparam int MOR_WDR = 3;
  localparam int MOR_WDW = 2;
  localparam int MOR_PDB = 1;
  localparam int MOR_PDC = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int POR_LOW_SHORT = 16;
  localparam int POR_LOW_LONG = 4064;
  localparam int GROUP_BYTES = 8;
endpackage

// >>> hdl/nvp_latch_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Eight-byte EPROM data latches with a registered read port.
module nvp_latch_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_i,
  input wire logic wr_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_reg [DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_reg[raddr_i];
  end
endmodule
`default_nettype wire

// >>> hdl/nvp_hold_cnt.sv
`timescale 1ns/1ps
`default_nettype none
// Down counter that reports busy while a loaded count runs out.
module nvp_hold_cnt #(
  parameter int W = 12
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [W-1:0] count_i,
  output logic busy_o
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = count_i;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign busy_o = (cnt_reg != '0);
endmodule
`default_nettype wire

// >>> hdl/nvp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module nvp_ctrl
  import nvp_pkg::*;
#(
  parameter int POR_LOW_LONG_P = POR_LOW_LONG
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic por_flag_i,
  input wire logic boot_mode_i,
  input wire logic stop_i,
  input wire logic wait_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] opt_array_i,
  input wire logic [7:0] mor_array_i,
  input wire logic [7:0] ddr_b_i,
  input wire logic [7:0] ddr_c_i,
  input wire logic [2:0] eprom_buf_idx_i,
  output logic [7:0] eprom_buf_data_o,
  output logic [7:0] eprom_buf_valid_o,
  output logic [12:0] eprom_group_o,
  output logic eprom_read_normal_o,
  output logic eprom_program_o,
  output logic eeprom_read_normal_o,
  output logic [7:0] eeprom_addr_o,
  output logic [7:0] eeprom_data_o,
  output logic eeprom_pump_o,
  output logic eeprom_erase_o,
  output logic eeprom_write_o,
  output logic eeprom_refused_o,
  output logic reset_pin_low_o,
  output logic watchdog_enable_o,
  output logic watchdog_run_o,
  output logic [7:0] pulldown_b_o,
  output logic [7:0] pulldown_c_o,
  output logic nonuser_allowed_o
);
  //////////////////////////////////////////////////////////////////////////
  // Decode of bus accesses.
  // Array windows are decoded here; the arrays themselves sit outside.
  logic ctrl_wr;
  logic ee_wr;
  logic ep_wr;
  logic in_ee;
  logic in_ep;

  assign in_ee = (addr_i >= EE_LO) && (addr_i <= EE_HI);
  assign in_ep = (addr_i >= EPROM_LO) && (addr_i <= EPROM_HI);
  assign ctrl_wr = wr_i && (addr_i == CTRL_ADDR);
  assign ee_wr = wr_i && in_ee;
  assign ep_wr = wr_i && in_ep;

  //////////////////////////////////////////////////////////////////////////
  // Control bits and capture state.
  logic ep_lat_reg, ep_lat_next;
  logic ep_pgm_reg, ep_pgm_next;
  logic ee_lat_reg, ee_lat_next;
  logic ee_pgm_reg, ee_pgm_next;
  logic ee_era_reg, ee_era_next;
  logic ee_cap_reg, ee_cap_next;
  logic [7:0] ee_addr_reg, ee_addr_next;
  logic [7:0] ee_data_reg, ee_data_next;
  logic [7:0] ep_valid_reg, ep_valid_next;
  logic [12:0] ep_group_reg, ep_group_next;
  logic ep_cap;
  logic ee_cap;

  assign ep_cap = ep_wr && ep_lat_reg && !ep_pgm_reg;
  assign ee_cap = ee_wr && ee_lat_reg && !ee_pgm_reg;

  always_comb begin
    ep_lat_next = ep_lat_reg;
    ep_pgm_next = ep_pgm_reg;
    ee_lat_next = ee_lat_reg;
    ee_pgm_next = ee_pgm_reg;
    ee_era_next = ee_era_reg;
    ee_cap_next = ee_cap_reg;
    ee_addr_next = ee_addr_reg;
    ee_data_next = ee_data_reg;
    ep_valid_next = ep_valid_reg;
    ep_group_next = ep_group_reg;
    if (ctrl_wr) begin
      ep_lat_next = wdata_i[CTRL_ELAT];
      // Program bit may only go from zero to one here.
      if (wdata_i[CTRL_EPGM] && ep_lat_reg && (ep_valid_reg != '0)) begin
        ep_pgm_next = 1'b1;
      end
      ee_lat_next = wdata_i[CTRL_ILAT];
      if (!ee_cap_reg) begin
        ee_era_next = wdata_i[CTRL_ERA];
      end
      if (wdata_i[CTRL_IPGM] && ee_cap_reg) begin
        ee_pgm_next = 1'b1;
      end
    end
    if (ep_cap) begin
      // First byte fixes the group; later bytes only fill slots.
      if (ep_valid_reg == '0) begin
        ep_group_next = addr_i[15:3];
      end
      ep_valid_next[addr_i[2:0]] = 1'b1;
    end
    if (ee_cap) begin
      ee_addr_next = addr_i[7:0];
      ee_data_next = wdata_i;
      ee_cap_next = 1'b1;
    end
    // STOP is applied last so it wins over a write in the same cycle.
    if (stop_i) begin
      ep_lat_next = 1'b0;
      ee_lat_next = 1'b0;
    end
    // Clearing a latch drops every bit that depends on it.
    if (!ep_lat_next) begin
      ep_pgm_next = 1'b0;
      ep_valid_next = '0;
    end
    if (!ee_lat_next) begin
      ee_pgm_next = 1'b0;
      ee_era_next = 1'b0;
      ee_cap_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ep_lat_reg <= 1'b0;
      ep_pgm_reg <= 1'b0;
      ee_lat_reg <= 1'b0;
      ee_pgm_reg <= 1'b0;
      ee_era_reg <= 1'b0;
      ee_cap_reg <= 1'b0;
      ee_addr_reg <= 8'h00;
      ee_data_reg <= 8'h00;
      ep_valid_reg <= 8'h00;
      ep_group_reg <= 13'h0000;
    end else begin
      ep_lat_reg <= ep_lat_next;
      ep_pgm_reg <= ep_pgm_next;
      ee_lat_reg <= ee_lat_next;
      ee_pgm_reg <= ee_pgm_next;
      ee_era_reg <= ee_era_next;
      ee_cap_reg <= ee_cap_next;
      ee_addr_reg <= ee_addr_next;
      ee_data_reg <= ee_data_next;
      ep_valid_reg <= ep_valid_next;
      ep_group_reg <= ep_group_next;
    end
  end

  // The byte store shares its write condition with the slot flags.
  nvp_latch_mem #(
    .DEPTH(GROUP_BYTES),
    .AW(3)
  ) u_mem (
    .clk_i(clk_i),
    .wr_i(ep_cap),
    .waddr_i(addr_i[2:0]),
    .wdata_i(wdata_i),
    .raddr_i(eprom_buf_idx_i),
    .rdata_o(eprom_buf_data_o)
  );

  //////////////////////////////////////////////////////////////////////////
  // Options taken while reset is applied and held until the next one.
  logic prot_reg, prot_next;
  logic lock_reg, lock_next;
  logic boot_reg, boot_next;
  logic por_reg, por_next;
  logic [7:0] mor_reg, mor_next;
  logic rst_d_reg;
  logic boot_meta_reg;
  logic boot_sync_reg;
  logic por_meta_reg;
  logic por_sync_reg;
  logic hold_load;
  logic hold_busy;
  logic [11:0] hold_count;

  // Mode and power-on flags come from pin logic, so they pass two stages.
  // A reset shorter than three cycles may therefore miss a new flag value.
  always_ff @(posedge clk_i) begin
    boot_meta_reg <= boot_mode_i;
    boot_sync_reg <= boot_meta_reg;
    por_meta_reg <= por_flag_i;
    por_sync_reg <= por_meta_reg;
  end

  always_comb begin
    prot_next = prot_reg;
    lock_next = lock_reg;
    boot_next = boot_reg;
    por_next = por_reg;
    mor_next = mor_reg;
    // Protection and lock are copied only in reset, so a later change of
    // the option byte waits for the next reset.
    if (reset_i) begin
      prot_next = !opt_array_i[OPT_PROT];
      lock_next = opt_array_i[OPT_LOCK];
      boot_next = boot_sync_reg;
      por_next = por_sync_reg;
      mor_next = mor_array_i;
    end
  end

  always_ff @(posedge clk_i) begin
    prot_reg <= prot_next;
    lock_reg <= lock_next;
    boot_reg <= boot_next;
    por_reg <= por_next;
    mor_reg <= mor_next;
    rst_d_reg <= reset_i;
  end

  // The hold count starts only when a power-on reset is released.
  assign hold_load = rst_d_reg && !reset_i && por_reg;
  assign hold_count = mor_reg[MOR_HOLD] ? 12'(POR_LOW_SHORT)
                                        : 12'(POR_LOW_LONG_P);

  nvp_hold_cnt #(
    .W(12)
  ) u_hold (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(hold_load),
    .count_i(hold_count),
    .busy_o(hold_busy)
  );

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs toward arrays, watchdog, ports and mode logic.
  // Every output is a register so the arrays and watchdog see clean levels.
  logic upper;
  logic refused;
  logic [7:0] rdata_next;
  logic [7:0] ctrl_view;
  logic pin_low_next;
  logic wd_run_next;
  logic [7:0] buf_valid_next;
  logic [12:0] group_out_next;
  logic ep_normal_next;
  logic ep_prog_next;
  logic ee_normal_next;
  logic [7:0] ee_addr_out_next;
  logic [7:0] ee_data_out_next;
  logic pump_out_next;
  logic erase_out_next;
  logic write_out_next;
  logic refused_out_next;
  logic wd_en_next;
  logic [7:0] pd_b_next;
  logic [7:0] pd_c_next;
  logic allowed_next;

  // The region test uses the captured offset, not the live bus address.
  assign upper = ({8'h01, ee_addr_reg} >= EE_UPPER_LO);
  assign refused = upper && prot_reg && !boot_reg;
  assign ctrl_view = {2'b00, ep_lat_reg, ep_pgm_reg, 1'b0,
                      ee_era_reg, ee_lat_reg, ee_pgm_reg};
  assign pin_low_next = reset_i || hold_load || hold_busy;
  assign wd_run_next = !(wait_i && !mor_reg[MOR_WDW]);

  always_comb begin
    rdata_next = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        CTRL_ADDR: rdata_next = ctrl_view;
        OPT_ADDR: rdata_next = opt_array_i;
        MOR_ADDR: rdata_next = mor_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // A refused operation keeps the pump off but still reports the attempt.
  always_comb begin
    buf_valid_next = ep_valid_reg;
    group_out_next = ep_group_reg;
    ep_normal_next = !ep_lat_reg;
    ep_prog_next = ep_lat_reg && ep_pgm_reg;
    ee_normal_next = !ee_lat_reg;
    ee_addr_out_next = ee_addr_reg;
    ee_data_out_next = ee_data_reg;
    pump_out_next = ee_pgm_reg && !refused;
    erase_out_next = ee_lat_reg && ee_pgm_reg && ee_era_reg
                     && !refused;
    write_out_next = ee_lat_reg && ee_pgm_reg && !ee_era_reg
                     && !refused;
    refused_out_next = ee_pgm_reg && refused;
    wd_en_next = mor_reg[MOR_WDR] && !boot_reg;
    pd_b_next = {8{mor_reg[MOR_PDB]}} & ~ddr_b_i;
    pd_c_next = {8{mor_reg[MOR_PDC]}} & ~ddr_c_i;
    allowed_next = lock_reg;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= CTRL_RESET;
      eprom_buf_valid_o <= 8'h00;
      eprom_group_o <= 13'h0000;
      eprom_read_normal_o <= 1'b1;
      eprom_program_o <= 1'b0;
      eeprom_read_normal_o <= 1'b1;
      eeprom_addr_o <= 8'h00;
      eeprom_data_o <= 8'h00;
      eeprom_pump_o <= 1'b0;
      eeprom_erase_o <= 1'b0;
      eeprom_write_o <= 1'b0;
      eeprom_refused_o <= 1'b0;
      reset_pin_low_o <= 1'b1;
      watchdog_enable_o <= 1'b0;
      watchdog_run_o <= 1'b0;
      pulldown_b_o <= 8'h00;
      pulldown_c_o <= 8'h00;
      nonuser_allowed_o <= 1'b0;
    end else begin
      rdata_o <= rdata_next;
      eprom_buf_valid_o <= buf_valid_next;
      eprom_group_o <= group_out_next;
      eprom_read_normal_o <= ep_normal_next;
      eprom_program_o <= ep_prog_next;
      eeprom_read_normal_o <= ee_normal_next;
      eeprom_addr_o <= ee_addr_out_next;
      eeprom_data_o <= ee_data_out_next;
      eeprom_pump_o <= pump_out_next;
      eeprom_erase_o <= erase_out_next;
      eeprom_write_o <= write_out_next;
      eeprom_refused_o <= refused_out_next;
      reset_pin_low_o <= pin_low_next;
      watchdog_enable_o <= wd_en_next;
      watchdog_run_o <= wd_run_next;
      pulldown_b_o <= pd_b_next;
      pulldown_c_o <= pd_c_next;
      nonuser_allowed_o <= allowed_next;
    end
  end
endmodule
`default_nettype wire

// >>> verification/nvp_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module nvp_ctrl_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic stop_i,
  input wire logic por_flag_i,
  input wire logic [7:0] ddr_b_i,
  input wire logic eprom_read_normal_o,
  input wire logic eprom_program_o,
  input wire logic eeprom_read_normal_o,
  input wire logic eeprom_pump_o,
  input wire logic eeprom_erase_o,
  input wire logic eeprom_write_o,
  input wire logic eeprom_refused_o,
  input wire logic reset_pin_low_o,
  input wire logic watchdog_enable_o,
  input wire logic nonuser_allowed_o,
  input wire logic [7:0] pulldown_b_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_prog_latch: assert property (eprom_program_o |-> !eprom_read_normal_o)
    else $error("eprom program without latch");
  a_stop_clear: assert property (stop_i |-> ##2
    (eprom_read_normal_o && eeprom_read_normal_o))
    else $error("stop left a latch set");
  a_pd_input: assert property ((pulldown_b_o & $past(ddr_b_i)) == 8'h00)
    else $error("pull-down on output pin");
  a_op_excl: assert property (!(eeprom_erase_o && eeprom_write_o))
    else $error("erase and program together");
  a_op_pump: assert property ((eeprom_erase_o || eeprom_write_o) |->
    eeprom_pump_o && !eeprom_read_normal_o)
    else $error("operation without pump");
  a_refused_off: assert property (eeprom_refused_o |->
    !eeprom_pump_o && !eeprom_erase_o && !eeprom_write_o)
    else $error("protected operation ran");
  a_latch_idle: assert property (eeprom_read_normal_o |->
    !(eeprom_pump_o || eeprom_refused_o))
    else $error("pump with latch clear");
  a_pin_release: assert property ($fell(reset_i) |-> reset_pin_low_o)
    else $error("reset pin released early");
  a_pin_hold: assert property ($fell(reset_i)
    && $past(por_flag_i) |-> reset_pin_low_o [*8])
    else $error("reset pin released before hold");
  a_opt_stable: assert property ((!$past(reset_i)
    && !$past(reset_i, 2)) |->
    $stable(nonuser_allowed_o) && $stable(watchdog_enable_o))
    else $error("option output moved");
  c_eprom: cover property (eprom_program_o);
  c_erase: cover property (eeprom_erase_o);
  c_refused: cover property (eeprom_refused_o);
endmodule
bind nvp_ctrl nvp_ctrl_checker u_chk (.*);
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 0, reset_i = 1, por_flag_i = 1, boot_mode_i = 0;
  logic stop_i = 0, wait_i = 0, wr_i = 0, rd_i = 0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00, opt_array_i = 8'h03, mor_array_i = 8'h0a;
  logic [7:0] ddr_b_i = 8'h0f, ddr_c_i = 8'h00;
  logic [2:0] eprom_buf_idx_i = 3'h7;
  logic [7:0] rdata_o, eprom_buf_data_o, eprom_buf_valid_o, eeprom_addr_o;
  logic [7:0] eeprom_data_o, pulldown_b_o, pulldown_c_o;
  logic [12:0] eprom_group_o;
  logic eprom_read_normal_o, eprom_program_o, eeprom_read_normal_o;
  logic eeprom_pump_o, eeprom_erase_o, eeprom_write_o, eeprom_refused_o;
  logic reset_pin_low_o, watchdog_enable_o, watchdog_run_o, nonuser_allowed_o;
  int num_errors = 0, total_checks = 0, n;
  logic [35:0] rows [19];
  wire [3:0] st = {eprom_program_o, eeprom_pump_o, eeprom_erase_o,
    eeprom_write_o};
  nvp_ctrl #(.POR_LOW_LONG_P(40)) DUT (.*);
  always #4 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  task automatic rst(input logic boot, input logic [7:0] mask_option_fuses, opt,
    input int len);
    @(posedge clk_i);
    reset_i <= 1'b1;
    por_flag_i <= 1'b1;
    boot_mode_i <= boot;
    mor_array_i <= mask_option_fuses;
    opt_array_i <= opt;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    por_flag_i <= 1'b0;
    n = 0;
    while (reset_pin_low_o !== 1'b0 && n < 5000) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk(n >= len && n <= len + 3, 1'b1);
  endtask
  task automatic upper(input logic refuse);
    wr(16'h0007, 8'h02);
    wr(16'h0130, 8'h44);
    wr(16'h0007, 8'h03);
    rd(16'h0007, 8'h03);
    chk(eeprom_refused_o, refuse);
    chk(eeprom_pump_o, !refuse);
    wr(16'h0007, 8'h00);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
  initial begin
    rows = '{
      {16'h0007, 8'h10, 8'h00, 4'h0}, {16'h0007, 8'h20, 8'h20, 4'h0},
      {16'h0007, 8'h30, 8'h20, 4'h0}, {16'h0808, 8'h5a, 8'h20, 4'h0},
      {16'h0007, 8'h30, 8'h30, 4'h8}, {16'h0007, 8'h20, 8'h30, 4'h8},
      {16'h0007, 8'h00, 8'h00, 4'h0}, {16'h0007, 8'h01, 8'h00, 4'h0},
      {16'h0007, 8'h02, 8'h02, 4'h0}, {16'h0007, 8'h03, 8'h02, 4'h0},
      {16'h0007, 8'h06, 8'h06, 4'h0}, {16'h0110, 8'haa, 8'h06, 4'h0},
      {16'h0007, 8'h02, 8'h06, 4'h0}, {16'h0007, 8'h07, 8'h07, 4'h6},
      {16'h0007, 8'h06, 8'h07, 4'h6}, {16'h0007, 8'h00, 8'h00, 4'h0},
      {16'h0007, 8'h02, 8'h02, 4'h0}, {16'h0120, 8'h33, 8'h02, 4'h0},
      {16'h0007, 8'h03, 8'h03, 4'h5}};
    rst(1'b0, 8'h0a, 8'h03, 40);
    chk(watchdog_enable_o, 1'b1);
    chk(nonuser_allowed_o, 1'b1);
    chk(pulldown_b_o, 8'hf0);
    chk(pulldown_c_o, 8'h00);
    chk(watchdog_run_o, 1'b1);
    rd(16'h3dfe, 8'h0a);
    rd(16'h0007, 8'h00);
    @(posedge clk_i);
    wait_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk(watchdog_run_o, 1'b0);
    foreach (rows[i]) begin
      wr(rows[i][35:20], rows[i][19:12]);
      rd(16'h0007, rows[i][11:4]);
      chk(st, rows[i][3:0]);
    end
    chk(eeprom_addr_o, 8'h20);
    chk(eeprom_data_o, 8'h33);
    wr(16'h0007, 8'h00);
    wr(16'h0007, 8'h20);
    wr(16'h0810, 8'h11);
    wr(16'h0817, 8'h22);
    repeat (2) @(posedge clk_i);
    #1 chk(eprom_buf_valid_o, 8'h81);
    chk(eprom_buf_data_o, 8'h22);
    chk(eprom_group_o, 13'h0102);
    @(posedge clk_i);
    eprom_buf_idx_i <= 3'h0;
    @(posedge clk_i);
    #1 chk(eprom_buf_data_o, 8'h11);
    wr(16'h0007, 8'h22);
    stop_i <= 1'b1;
    @(posedge clk_i);
    stop_i <= 1'b0;
    opt_array_i <= 8'h00;
    rd(16'h0007, 8'h00);
    chk(eprom_read_normal_o, 1'b1);
    chk(eeprom_read_normal_o, 1'b1);
    chk(nonuser_allowed_o, 1'b1);
    rst(1'b0, 8'h1a, 8'h00, 16);
    chk(nonuser_allowed_o, 1'b0);
    upper(1'b1);
    rst(1'b1, 8'h1e, 8'h00, 16);
    chk(watchdog_enable_o, 1'b0);
    chk(watchdog_run_o, 1'b1);
    upper(1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
